// File: core/slnsp_chk.sv
`timescale 1ns/1ps
`default_nettype none
module slnsp_chk
	import slnsp_pkg::*;
(
	slnsp_chk_if.chk c // address to check and verdicts
);
	always_comb
	begin
		c.ovf = c.valid & c.sp_use & (c.addr > c.limit);
		c.unf = c.valid & c.sp_use & (c.addr < SLNSP_UNF_FLOOR);
		c.mis = c.valid & c.word & c.addr[0];
	end
endmodule : slnsp_chk
`default_nettype wire

// File: core/slnsp_near.sv
`timescale 1ns/1ps
`default_nettype none
module slnsp_near
	import slnsp_pkg::*;
(
	input wire logic pclk, // core clock
	input wire logic presetn, // async reset, active low
	slnsp_near_if.dec n // direct address request and result
);
	logic [15:0] addr_reg, addr_next;
	logic valid_reg, valid_next;
	logic near_reg, near_next;

	always_comb
	begin
		valid_next = n.valid;
		addr_next = addr_reg;
		near_next = near_reg;
		if (n.valid)
		begin
			// move reaches all of X space, others only the near region
			if (n.move)
				addr_next = n.field;
			else
				addr_next = n.field & SLNSP_NEAR_MASK;
			near_next = (addr_next <= SLNSP_NEAR_TOP);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			addr_reg <= 16'h0000;
			valid_reg <= 1'b0;
			near_reg <= 1'b0;
		end
		else
		begin
			addr_reg <= addr_next;
			valid_reg <= valid_next;
			near_reg <= near_next;
		end
	end

	assign n.addr = addr_reg;
	assign n.addr_valid = valid_reg;
	assign n.near = near_reg;

	AST_NEAR_DIRECT: assert property (@(posedge pclk) disable iff (!presetn)
		n.valid && !n.move |=> n.addr <= SLNSP_NEAR_TOP && n.near)
		else $error("non-move direct address left the near region");
	AST_MOVE_FULL: assert property (@(posedge pclk) disable iff (!presetn)
		n.valid && n.move |=> n.addr == $past(n.field))
		else $error("move direct address not passed in full");
endmodule : slnsp_near
`default_nettype wire

// File: core/slnsp_top.sv
`timescale 1ns/1ps
`default_nettype none
module slnsp_top
	import slnsp_pkg::*;
(
	input wire logic pclk, // core clock
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire logic op_valid, // stack operation request
	input wire slnsp_op_t op_kind, // push, pop, call, exception
	input wire logic [15:0] op_wdata, // data word to push
	input wire logic [23:0] op_pc, // program counter to push
	input wire logic [7:0] status_low_byte, // status byte for exceptions
	output logic op_ready, // request can be taken
	output logic mem_valid, // stack memory access
	output logic mem_write, // access is a write
	output logic [15:0] mem_addr, // stack memory address
	output logic [15:0] mem_wdata, // stack memory write data
	input wire logic ea_valid, // other effective address valid
	input wire logic [15:0] ea_addr, // effective address
	input wire logic ea_word, // word sized access
	input wire logic ea_write, // access is a write
	input wire logic ea_sp, // address formed from stack pointer
	output logic ea_write_ok, // write may proceed
	input wire logic dir_valid, // direct address request
	input wire logic dir_move, // request from move instruction
	input wire logic [15:0] dir_field, // address field of instruction
	output logic [15:0] dir_addr, // decoded direct address
	output logic dir_addr_valid, // decoded address valid
	output logic dir_near, // address lies in near space
	output logic stack_err, // stack error trap request
	output logic addr_err, // address error trap request
	output logic irq // level interrupt
);
	localparam logic [11:0] A_SP = slnsp_byte_addr(SLNSP_IDX_SP);
	localparam logic [11:0] A_LIM = slnsp_byte_addr(SLNSP_IDX_LIM);
	localparam logic [11:0] A_STAT = slnsp_byte_addr(SLNSP_IDX_STAT);
	localparam logic [11:0] A_CLR = slnsp_byte_addr(SLNSP_IDX_CLR);
	localparam logic [11:0] A_EN = slnsp_byte_addr(SLNSP_IDX_EN);

	typedef enum logic {S_IDLE, S_UPPER} slnsp_state_t;

	slnsp_state_t state_reg, state_next;
	logic [15:0] sp_reg, sp_next;
	logic [15:0] lim_reg, lim_next;
	logic [15:0] upper_reg, upper_next;
	logic mem_valid_reg, mem_valid_next;
	logic mem_write_reg, mem_write_next;
	logic [15:0] mem_addr_reg, mem_addr_next;
	logic [15:0] mem_wdata_reg, mem_wdata_next;
	logic [2:0] stat_reg, stat_next;
	logic [2:0] en_reg, en_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pslverr_reg, pslverr_next;
	logic apb_setup;
	logic apb_wr;
	logic [2:0] events;

	slnsp_chk_if stk_c();
	slnsp_chk_if ea_c();
	slnsp_near_if near_c();

	slnsp_chk u_stk_chk (
		.c(stk_c)
	);
	slnsp_chk u_ea_chk (
		.c(ea_c)
	);
	slnsp_near u_near (
		.pclk(pclk),
		.presetn(presetn),
		.n(near_c)
	);

	assign stk_c.valid = mem_valid_reg;
	assign stk_c.addr = mem_addr_reg;
	assign stk_c.word = 1'b1;
	assign stk_c.sp_use = 1'b1;
	assign stk_c.limit = lim_reg;
	assign ea_c.valid = ea_valid;
	assign ea_c.addr = ea_addr;
	assign ea_c.word = ea_word;
	assign ea_c.sp_use = ea_sp;
	assign ea_c.limit = lim_reg;
	assign near_c.valid = dir_valid;
	assign near_c.move = dir_move;
	assign near_c.field = dir_field;
	assign dir_addr = near_c.addr;
	assign dir_addr_valid = near_c.addr_valid;
	assign dir_near = near_c.near;

	// traps raised in the cycle the address is presented
	assign stack_err = stk_c.ovf | stk_c.unf | ea_c.ovf | ea_c.unf;
	assign addr_err = stk_c.mis | ea_c.mis;
	assign ea_write_ok = ea_valid & ea_write & ~ea_c.mis;

	assign apb_setup = psel & ~penable;
	assign apb_wr = psel & penable & pwrite;

	// stack sequencer
	always_comb
	begin
		state_next = state_reg;
		sp_next = sp_reg;
		upper_next = upper_reg;
		mem_valid_next = 1'b0;
		mem_write_next = 1'b0;
		mem_addr_next = mem_addr_reg;
		mem_wdata_next = mem_wdata_reg;
		case (state_reg)
			S_IDLE:
			begin
				if (op_valid)
				begin
					mem_valid_next = 1'b1;
					case (op_kind)
						OP_POP:
						begin
							sp_next = sp_reg - SLNSP_WORD_STEP;
							mem_addr_next = sp_next;
						end
						OP_PUSH:
						begin
							mem_write_next = 1'b1;
							mem_addr_next = sp_reg;
							mem_wdata_next = op_wdata;
							sp_next = sp_reg + SLNSP_WORD_STEP;
						end
						default:
						begin
							mem_write_next = 1'b1;
							mem_addr_next = sp_reg;
							mem_wdata_next = op_pc[15:0];
							sp_next = sp_reg + SLNSP_WORD_STEP;
							if (op_kind == OP_EXC)
								upper_next = slnsp_upper_word(status_low_byte,
									op_pc[23:16]);
							else
								upper_next = slnsp_upper_word(SLNSP_CALL_MSB,
									op_pc[23:16]);
							state_next = S_UPPER;
						end
					endcase
				end
				else if (apb_wr && paddr == A_SP)
					sp_next = pwdata[15:0] & SLNSP_ALIGN_MASK;
			end
			S_UPPER:
			begin
				mem_valid_next = 1'b1;
				mem_write_next = 1'b1;
				mem_addr_next = sp_reg;
				mem_wdata_next = upper_reg;
				sp_next = sp_reg + SLNSP_WORD_STEP;
				state_next = S_IDLE;
			end
			default:
				state_next = S_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= S_IDLE;
			sp_reg <= SLNSP_SP_RST;
			upper_reg <= 16'h0000;
			mem_valid_reg <= 1'b0;
			mem_write_reg <= 1'b0;
			mem_addr_reg <= 16'h0000;
			mem_wdata_reg <= 16'h0000;
		end
		else
		begin
			state_reg <= state_next;
			sp_reg <= sp_next;
			upper_reg <= upper_next;
			mem_valid_reg <= mem_valid_next;
			mem_write_reg <= mem_write_next;
			mem_addr_reg <= mem_addr_next;
			mem_wdata_reg <= mem_wdata_next;
		end
	end

	assign op_ready = (state_reg == S_IDLE);
	assign mem_valid = mem_valid_reg;
	assign mem_write = mem_write_reg;
	assign mem_addr = mem_addr_reg;
	assign mem_wdata = mem_wdata_reg;

	// registers, interrupt status and apb read path
	always_comb
	begin
		lim_next = lim_reg;
		en_next = en_reg;
		events = 3'h0;
		events[SLNSP_ST_OVF] = stk_c.ovf | ea_c.ovf;
		events[SLNSP_ST_UNF] = stk_c.unf | ea_c.unf;
		events[SLNSP_ST_ADR] = addr_err;
		stat_next = stat_reg;
		prdata_next = prdata_reg;
		pslverr_next = pslverr_reg;
		// limit write lands at the access edge; no extra forwarding
		if (apb_wr && paddr == A_LIM)
			lim_next = pwdata[15:0] & SLNSP_ALIGN_MASK;
		if (apb_wr && paddr == A_EN)
			en_next = pwdata[SLNSP_ST_W-1:0];
		if (apb_wr && paddr == A_CLR)
			stat_next = stat_reg & ~pwdata[SLNSP_ST_W-1:0];
		stat_next = stat_next | events;
		if (apb_setup)
		begin
			prdata_next = 32'h0000_0000;
			pslverr_next = 1'b0;
			case (paddr)
				A_SP: prdata_next[15:0] = sp_reg;
				A_LIM: prdata_next[15:0] = lim_reg;
				A_STAT: prdata_next[SLNSP_ST_W-1:0] = stat_reg;
				A_EN: prdata_next[SLNSP_ST_W-1:0] = en_reg;
				A_CLR: prdata_next = 32'h0000_0000;
				default: pslverr_next = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lim_reg <= SLNSP_LIM_RST;
			en_reg <= SLNSP_STAT_RST;
			stat_reg <= SLNSP_STAT_RST;
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end
		else
		begin
			lim_reg <= lim_next;
			en_reg <= en_next;
			stat_reg <= stat_next;
			prdata_reg <= prdata_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg & psel & penable;
	assign pready = 1'b1;
	assign irq = |(stat_reg & en_reg);

	AST_PUSH_POST_INC: assert property (@(posedge pclk) disable iff (!presetn)
		op_valid && op_ready && op_kind == OP_PUSH |=>
		mem_write && mem_addr == $past(sp_reg) &&
		sp_reg == $past(sp_reg) + SLNSP_WORD_STEP)
		else $error("push did not write then increment");
	AST_POP_PRE_DEC: assert property (@(posedge pclk) disable iff (!presetn)
		op_valid && op_ready && op_kind == OP_POP |=>
		!mem_write && mem_addr == sp_reg &&
		sp_reg == $past(sp_reg) - SLNSP_WORD_STEP)
		else $error("pop did not decrement then read");
	AST_CALL_UPPER: assert property (@(posedge pclk) disable iff (!presetn)
		op_valid && op_ready && op_kind == OP_CALL |=>
		##1 mem_write && mem_wdata[15:8] == SLNSP_CALL_MSB)
		else $error("call upper word byte not cleared");
	AST_EXC_UPPER: assert property (@(posedge pclk) disable iff (!presetn)
		op_valid && op_ready && op_kind == OP_EXC |=>
		##1 mem_wdata[15:8] == $past(status_low_byte, 2))
		else $error("exception upper byte not status");
	AST_SP_EVEN: assert property (@(posedge pclk) disable iff (!presetn)
		!sp_reg[0] && !lim_reg[0])
		else $error("stack pointer or limit not word aligned");
	AST_AT_LIMIT: assert property (@(posedge pclk) disable iff (!presetn)
		mem_valid && mem_write && mem_addr == lim_reg &&
		mem_addr >= SLNSP_UNF_FLOOR |-> !(stk_c.ovf || stk_c.unf))
		else $error("push at the limit trapped");
	AST_BEYOND: assert property (@(posedge pclk) disable iff (!presetn)
		mem_valid && mem_addr > lim_reg |-> stack_err ##1
		stat_reg[SLNSP_ST_OVF])
		else $error("stack overflow not flagged");
	AST_UNDERFLOW: assert property (@(posedge pclk) disable iff (!presetn)
		ea_valid && ea_sp && ea_addr < SLNSP_UNF_FLOOR |-> stack_err)
		else $error("stack underflow not flagged");
	AST_MIS_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		ea_valid && ea_word && ea_addr[0] |-> addr_err && !ea_write_ok)
		else $error("misaligned write not suppressed");
endmodule : slnsp_top
`default_nettype wire

// File: dv/slnsp_stk_mem.sv
`timescale 1ns/1ps
`default_nettype none
module slnsp_stk_mem
(
	input wire logic pclk, // core clock
	input wire logic mem_valid, // stack access strobe
	input wire logic mem_write, // access is a write
	input wire logic [15:0] mem_addr, // byte address
	input wire logic [15:0] mem_wdata // write data
);
	// word store for the stack window 0x0800 upward
	logic [15:0] mem [0:255];
	always_ff @(posedge pclk)
	begin
		if (mem_valid && mem_write)
			mem[mem_addr[8:1]] <= mem_wdata;
	end
endmodule : slnsp_stk_mem
`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import slnsp_pkg::*;
;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic pready, pslverr, op_valid = 0, op_ready, e;
	slnsp_op_t op_kind = OP_PUSH;
	logic [15:0] op_wdata = 0, mem_addr, mem_wdata, ea_addr = 0;
	logic [23:0] op_pc = 0;
	logic [7:0] status_low_byte = 0;
	logic mem_valid, mem_write, ea_valid = 0, ea_word = 0;
	logic ea_write = 0, ea_sp = 0, ea_write_ok, dir_valid = 0;
	logic dir_move = 0, dir_addr_valid, dir_near, stack_err;
	logic addr_err, irq;
	logic [15:0] dir_field = 0, dir_addr;
	int n_errors = 0, checks = 0, cyc = 0;
	always #5 pclk = ~pclk;
	slnsp_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .op_valid(op_valid), .op_kind(op_kind),
		.op_wdata(op_wdata), .op_pc(op_pc),
		.status_low_byte(status_low_byte), .op_ready(op_ready),
		.mem_valid(mem_valid), .mem_write(mem_write),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.ea_valid(ea_valid), .ea_addr(ea_addr), .ea_word(ea_word),
		.ea_write(ea_write), .ea_sp(ea_sp), .ea_write_ok(ea_write_ok),
		.dir_valid(dir_valid), .dir_move(dir_move),
		.dir_field(dir_field), .dir_addr(dir_addr),
		.dir_addr_valid(dir_addr_valid), .dir_near(dir_near),
		.stack_err(stack_err), .addr_err(addr_err), .irq(irq));
	slnsp_stk_mem p (.pclk(pclk), .mem_valid(mem_valid),
		.mem_write(mem_write), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata));
	task close_out;
		if (n_errors == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc > 5000)
		begin
			n_errors++;
			close_out();
		end
	end
	task check(input string nm, input logic [31:0] s, input logic [31:0] x);
		checks++;
		if (s !== x)
		begin
			n_errors++;
			$display("CHECK FAILED %s exp %h got %h", nm, x, s);
		end
	endtask : check
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
		apb(0, a, 0);
		check("prdata", r, x);
		check("pslverr", e, xe);
	endtask : rd
	task op(input slnsp_op_t k, input logic [15:0] d, input logic [15:0] ad,
		input logic w, input logic er);
		@(posedge pclk);
		op_valid <= 1;
		op_kind <= k;
		op_wdata <= d;
		do @(posedge pclk); while (op_ready !== 1'b1);
		op_valid <= 0;
		@(negedge pclk);
		check("mem_valid", mem_valid, 1);
		check("mem_write", mem_write, w);
		check("mem_addr", mem_addr, ad);
		check("stack_err", stack_err, er);
		@(negedge pclk);
		check("stack_err next", stack_err, 0);
	endtask : op
	task ea(input logic [15:0] a, input logic wd, wr, sp, xs, xa, xo);
		@(posedge pclk);
		ea_valid <= 1;
		ea_addr <= a;
		ea_word <= wd;
		ea_write <= wr;
		ea_sp <= sp;
		@(negedge pclk);
		check("ea stack_err", stack_err, xs);
		check("ea addr_err", addr_err, xa);
		check("ea_write_ok", ea_write_ok, xo);
		@(posedge pclk);
		ea_valid <= 0;
	endtask : ea
	task dir(input logic [15:0] f, input logic mv, input logic [15:0] x,
		input logic nr);
		@(posedge pclk);
		dir_valid <= 1;
		dir_move <= mv;
		dir_field <= f;
		@(posedge pclk);
		dir_valid <= 0;
		@(negedge pclk);
		check("dir_addr_valid", dir_addr_valid, 1);
		check("dir_addr", dir_addr, x);
		check("dir_near", dir_near, nr);
	endtask : dir
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1;
		rd(12'h078, 32'h0800, 0);
		rd(12'h080, 32'h0, 0);
		rd(12'h0C0, 32'h0, 0);
		rd(12'h100, 32'h0, 1);
		apb(1, 12'h080, 32'h0803);
		rd(12'h080, 32'h0802, 0);
		op(OP_PUSH, 16'h1111, 16'h0800, 1, 0);
		op(OP_PUSH, 16'h2222, 16'h0802, 1, 0);
		op(OP_PUSH, 16'h3333, 16'h0804, 1, 1);
		check("mem 0802", p.mem[1], 16'h2222);
		rd(12'h078, 32'h0806, 0);
		rd(12'h0C0, 32'h1, 0);
		apb(1, 12'h0C8, 32'h7);
		// enable lands at the access edge; look once it has settled
		@(negedge pclk);
		check("irq set", irq, 1);
		apb(1, 12'h0C4, 32'h1);
		rd(12'h0C0, 32'h0, 0);
		check("irq clr", irq, 0);
		apb(1, 12'h080, 32'h1FFE);
		op(OP_POP, 16'h0, 16'h0804, 0, 0);
		op(OP_POP, 16'h0, 16'h0802, 0, 0);
		op_pc <= 24'hAB1234;
		op(OP_CALL, 16'h0, 16'h0802, 1, 0);
		status_low_byte <= 8'h5A;
		op_pc <= 24'hCD5678;
		op(OP_EXC, 16'h0, 16'h0806, 1, 0);
		// upper word reaches the stack store one edge later
		@(negedge pclk);
		check("call lo", p.mem[1], 16'h1234);
		check("call hi", p.mem[2], 16'h00AB);
		check("exc lo", p.mem[3], 16'h5678);
		check("exc hi", p.mem[4], 16'h5ACD);
		rd(12'h078, 32'h080A, 0);
		apb(1, 12'h078, 32'h0800);
		op(OP_POP, 16'h0, 16'h07FE, 0, 1);
		rd(12'h0C0, 32'h2, 0);
		check("irq unf", irq, 1);
		apb(1, 12'h0C8, 32'h1);
		@(negedge pclk);
		check("irq masked", irq, 0);
		apb(1, 12'h0C4, 32'h7);
		// a spare cycle follows the status clear write before stack reads
		ea(16'h2000, 1, 0, 1, 1, 0, 0);
		ea(16'h1FFE, 1, 0, 1, 0, 0, 0);
		ea(16'h07FE, 1, 0, 1, 1, 0, 0);
		ea(16'h1001, 1, 1, 0, 0, 1, 0);
		ea(16'h1000, 1, 1, 0, 0, 0, 1);
		ea(16'h1001, 0, 1, 0, 0, 0, 1);
		ea(16'h1003, 1, 0, 0, 0, 1, 0);
		rd(12'h0C0, 32'h7, 0);
		dir(16'hFFFF, 0, 16'h1FFF, 1);
		dir(16'h1FFF, 0, 16'h1FFF, 1);
		dir(16'h2000, 1, 16'h2000, 0);
		dir(16'hFFFE, 1, 16'hFFFE, 0);
		close_out();
	end
endmodule : tb_top
`default_nettype wire

// File: inc/slnsp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface slnsp_chk_if;
	logic valid;
	logic [15:0] addr;
	logic word;
	logic sp_use;
	logic [15:0] limit;
	logic ovf;
	logic unf;
	logic mis;
	modport src(output valid, addr, word, sp_use, limit,
		input ovf, unf, mis);
	modport chk(input valid, addr, word, sp_use, limit,
		output ovf, unf, mis);
endinterface : slnsp_chk_if

interface slnsp_near_if;
	logic valid;
	logic move;
	logic [15:0] field;
	logic [15:0] addr;
	logic addr_valid;
	logic near;
	modport src(output valid, move, field, input addr, addr_valid, near);
	modport dec(input valid, move, field, output addr, addr_valid, near);
endinterface : slnsp_near_if
`default_nettype wire

// File: inc/slnsp_pkg.sv
package slnsp_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] SLNSP_IDX_SP = 8'h1E;
	localparam logic [7:0] SLNSP_IDX_LIM = 8'h20;
	localparam logic [7:0] SLNSP_IDX_STAT = 8'h30;
	localparam logic [7:0] SLNSP_IDX_CLR = 8'h31;
	localparam logic [7:0] SLNSP_IDX_EN = 8'h32;
	localparam logic [15:0] SLNSP_SP_RST = 16'h0800;
	localparam logic [15:0] SLNSP_LIM_RST = 16'h0000;
	localparam logic [15:0] SLNSP_UNF_FLOOR = 16'h0800;
	localparam logic [15:0] SLNSP_NEAR_TOP = 16'h1FFF;
	localparam logic [15:0] SLNSP_NEAR_MASK = 16'h1FFF;
	localparam logic [15:0] SLNSP_WORD_STEP = 16'h0002;
	localparam logic [15:0] SLNSP_ALIGN_MASK = 16'hFFFE;
	localparam logic [7:0] SLNSP_CALL_MSB = 8'h00;
	localparam logic [2:0] SLNSP_STAT_RST = 3'h0;
	localparam int SLNSP_ST_OVF = 0;
	localparam int SLNSP_ST_UNF = 1;
	localparam int SLNSP_ST_ADR = 2;
	localparam int SLNSP_ST_W = 3;

	typedef enum logic [1:0] {OP_PUSH, OP_POP, OP_CALL, OP_EXC} slnsp_op_t;

	function automatic logic [11:0] slnsp_byte_addr(input logic [7:0] idx);
		return {2'h0, idx, 2'h0};
	endfunction : slnsp_byte_addr

	function automatic logic [15:0] slnsp_upper_word(input logic [7:0] msb,
		input logic [7:0] pc_hi);
		return {msb, pc_hi};
	endfunction : slnsp_upper_word
endpackage : slnsp_pkg
